// File: sle_lamp_viewer.sv
`timescale 1ns/1ns
// ****************************************
// Operator view of the lamp bank
// ****************************************
module sle_lamp_viewer (
    // Clock
    input wire logic clk_sys,
    // Lamp drive and what the eye catches
    input wire sle_pkg::sle_color_t lamp_color [sle_pkg::SLE_NUM_LAMPS],
    output sle_pkg::sle_color_t seen [sle_pkg::SLE_NUM_LAMPS]
);
    import sle_pkg::*;
    // Glitches shorter than a clock are invisible, so sample once per edge
    always_ff @(posedge clk_sys) begin
        seen <= lamp_color;
    end
endmodule : sle_lamp_viewer

// File: sle_pkg.sv
package sle_pkg;
    // ****************************************
    // Lamp colour encoding
    // ****************************************
    typedef logic [2:0] sle_color_t;
    localparam sle_color_t SLE_OFF = 3'h0;
    localparam sle_color_t SLE_GREEN = 3'h1;
    localparam sle_color_t SLE_RED = 3'h2;
    localparam sle_color_t SLE_YELLOW = 3'h3;
    localparam sle_color_t SLE_BLUE = 3'h4;
    localparam sle_color_t SLE_ORANGE = 3'h5;
    localparam int SLE_COLOR_W = 3;
    localparam int SLE_NUM_LAMPS = 11;

    // ****************************************
    // Timing
    // ****************************************
    localparam int SLE_CLK_MHZ = 100;
    localparam int SLE_BLINK_MS = 333;
    localparam int SLE_BLINK_CYC = SLE_BLINK_MS * SLE_CLK_MHZ * 1000;
    localparam int SLE_PRESC_W = 26;

    // ****************************************
    // Register map (AXI4-Lite, byte offsets)
    // ****************************************
    localparam logic [7:0] SLE_REG_CTRL = 8'h00;
    localparam logic [7:0] SLE_REG_STAT = 8'h04;
    localparam logic [7:0] SLE_REG_IRQ_STAT = 8'h08;
    localparam logic [7:0] SLE_REG_IRQ_MASK = 8'h0c;
    localparam logic [7:0] SLE_REG_LAMP_LO = 8'h10;
    localparam logic [7:0] SLE_REG_LAMP_HI = 8'h14;
    localparam int SLE_CTRL_ENABLE = 0;
    localparam int SLE_CTRL_LAMPTEST = 1;
    localparam logic [1:0] SLE_CTRL_RST = 2'h1;
    localparam int SLE_IRQ_W = 3;
    localparam int SLE_IRQ_ERR = 0;
    localparam int SLE_IRQ_PWR_FAIL = 1;
    localparam int SLE_IRQ_NET_FAIL = 2;
    localparam logic [1:0] SLE_RESP_OKAY = 2'h0;
    localparam logic [1:0] SLE_RESP_SLVERR = 2'h2;
endpackage : sle_pkg

// File: sle_status_lamp_encoder.sv
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ns
module sle_status_lamp_encoder (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Device state inputs (asynchronous)
    input wire logic powered_on,
    input wire logic safety_switch_output_on,
    input wire logic device_error,
    input wire logic restart_interlock_blocked,
    input wire logic prot_field_occupied,
    input wire logic linked_sensor_enabled,
    input wire logic warn_field_int,
    input wire logic four_field_mode,
    input wire logic warn_field2_int,
    input wire logic warn_field3_int,
    input wire logic self_test_fail,
    input wire logic internal_comm_fault,
    input wire logic wave_active,
    input wire logic safety_proto_init,
    input wire logic safety_proto_active,
    input wire logic safety_proto_passive,
    input wire logic safety_proto_cfg_fail,
    input wire logic safety_proto_comm_err,
    input wire logic net_init,
    input wire logic net_bus_init,
    input wire logic net_data_exchange,
    input wire logic net_topology_err,
    input wire logic net_cfg_fail,
    input wire logic net_bus_err,
    input wire logic [1:0] port_link,
    input wire logic [1:0] port_activity,
    // Lamp outputs, index k at bits [3k+2:3k], lamp 1 = index 0
    output sle_pkg::sle_color_t lamp_color [sle_pkg::SLE_NUM_LAMPS],
    output logic irq
);
    import sle_pkg::*;

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int NIN = 28;
    logic [NIN-1:0] in_raw;
    logic [NIN-1:0] sync1_r;
    logic [NIN-1:0] sync2_r;
    assign in_raw = {port_activity, port_link, net_bus_err, net_cfg_fail, net_topology_err,
        net_data_exchange, net_bus_init, net_init, safety_proto_comm_err,
        safety_proto_cfg_fail, safety_proto_passive, safety_proto_active,
        safety_proto_init, wave_active, internal_comm_fault, self_test_fail,
        warn_field3_int, warn_field2_int, four_field_mode, warn_field_int,
        linked_sensor_enabled, prot_field_occupied, restart_interlock_blocked,
        device_error, safety_switch_output_on, powered_on};

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= in_raw;
            sync2_r <= sync1_r;
        end
    end

    wire s_pwr = sync2_r[0];
    wire s_sso = sync2_r[1];
    wire s_err = sync2_r[2];
    wire s_ri_blk = sync2_r[3];
    wire s_pf_occ = sync2_r[4];
    wire s_lnk_en = sync2_r[5];
    wire s_wf = sync2_r[6];
    wire s_four = sync2_r[7];
    wire s_wf2 = sync2_r[8];
    wire s_wf3 = sync2_r[9];
    wire s_stf = sync2_r[10];
    wire s_icf = sync2_r[11];
    wire s_wave = sync2_r[12];
    wire s_sp_init = sync2_r[13];
    wire s_sp_act = sync2_r[14];
    wire s_sp_pas = sync2_r[15];
    wire s_sp_cfg = sync2_r[16];
    wire s_sp_com = sync2_r[17];
    wire s_n_init = sync2_r[18];
    wire s_n_bus_init = sync2_r[19];
    wire s_n_dx = sync2_r[20];
    wire s_n_topo = sync2_r[21];
    wire s_n_cfg = sync2_r[22];
    wire s_n_bus_err = sync2_r[23];
    wire [1:0] s_plink = sync2_r[25:24];
    wire [1:0] s_pact = sync2_r[27:26];

    // ****************************************
    // Blink generator
    // ****************************************
    // One shared phase so every flashing lamp is in step
    localparam logic [SLE_PRESC_W-1:0] PRESC_MAX = SLE_PRESC_W'(SLE_BLINK_CYC - 1);
    logic [SLE_PRESC_W-1:0] presc_r;
    logic blink_r;
    wire blink_tick = (presc_r == PRESC_MAX);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            presc_r <= '0;
            blink_r <= 1'b0;
        end else begin
            presc_r <= blink_tick ? '0 : presc_r + 1'b1;
            if (blink_tick) begin
                blink_r <= ~blink_r;
            end
        end
    end

    function automatic sle_color_t flash(input sle_color_t c, input logic ph);
        return ph ? c : SLE_OFF;
    endfunction : flash

    // ****************************************
    // Control register
    // ****************************************
    logic [1:0] ctrl_r;
    wire en = ctrl_r[SLE_CTRL_ENABLE];
    wire lamptest = ctrl_r[SLE_CTRL_LAMPTEST];

    // ****************************************
    // Lamp encoding (error first within each lamp)
    // ****************************************
    sle_color_t enc [SLE_NUM_LAMPS];

    assign enc[0] = !s_pwr ? SLE_OFF :
        s_err ? flash(SLE_RED, blink_r) :
        s_sso ? SLE_GREEN : SLE_RED;
    assign enc[1] = !s_ri_blk ? SLE_OFF :
        s_pf_occ ? flash(SLE_YELLOW, blink_r) :
        s_lnk_en ? SLE_YELLOW : SLE_OFF;
    assign enc[2] = s_wf ? SLE_BLUE : SLE_OFF;
    assign enc[3] = (s_four && s_wf3) ? SLE_BLUE : SLE_OFF;
    assign enc[4] = (s_four && s_wf2) ? flash(SLE_YELLOW, blink_r) : SLE_OFF;
    assign enc[5] = SLE_OFF;
    assign enc[6] = !s_pwr ? SLE_OFF :
        (s_stf || s_icf) ? SLE_RED :
        s_wave ? flash(SLE_GREEN, blink_r) : SLE_GREEN;
    assign enc[7] = s_sp_com ? SLE_RED :
        s_sp_cfg ? flash(SLE_RED, blink_r) :
        (s_sp_pas || s_wave) ? flash(SLE_GREEN, blink_r) :
        (s_sp_init && s_sp_act) ? SLE_GREEN : SLE_OFF;
    assign enc[8] = s_n_bus_err ? SLE_RED :
        s_n_cfg ? flash(SLE_RED, blink_r) :
        s_n_topo ? flash(SLE_ORANGE, blink_r) :
        (s_n_bus_init || s_wave) ? flash(SLE_GREEN, blink_r) :
        (s_n_init && s_n_dx) ? SLE_GREEN : SLE_OFF;

    genvar gp;
    generate
        for (gp = 0; gp < 2; gp++) begin : g_port
            assign enc[9+gp] = !s_plink[gp] ? SLE_OFF :
                s_pact[gp] ? (blink_r ? SLE_ORANGE : SLE_GREEN) : SLE_GREEN;
        end
    endgenerate

    // Lamp outputs registered; disable blanks all, lamp test lights all green
    genvar gl;
    generate
        for (gl = 0; gl < SLE_NUM_LAMPS; gl++) begin : g_lamp
            always_ff @(posedge clk_sys) begin
                if (!rst_n) begin
                    lamp_color[gl] <= SLE_OFF;
                end else begin
                    lamp_color[gl] <= !en ? SLE_OFF : lamptest ? SLE_GREEN : enc[gl];
                end
            end
        end
    endgenerate

    // ****************************************
    // Interrupts: rising edge of fault states
    // ****************************************
    logic [SLE_IRQ_W-1:0] ev_prev_r;
    logic [SLE_IRQ_W-1:0] irq_stat_r;
    logic [SLE_IRQ_W-1:0] irq_mask_r;
    wire [SLE_IRQ_W-1:0] ev_lvl = {s_n_bus_err | s_n_cfg, s_stf | s_icf, s_err};
    wire [SLE_IRQ_W-1:0] ev_rise = ev_lvl & ~ev_prev_r;
    assign irq = |(irq_stat_r & irq_mask_r);

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic aw_hold_r;
    logic w_hold_r;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r;
    logic [3:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [31:0] rdata_r;
    logic [1:0] rresp_r;

    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready = !w_hold_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    wire aw_have = aw_hold_r || (s_axi_awvalid && s_axi_awready);
    wire w_have = w_hold_r || (s_axi_wvalid && s_axi_wready);
    wire [7:0] wa = aw_hold_r ? aw_addr_r : s_axi_awaddr;
    wire [31:0] wd = w_hold_r ? w_data_r : s_axi_wdata;
    wire [3:0] ws = w_hold_r ? w_strb_r : s_axi_wstrb;
    wire do_wr = aw_have && w_have && !bvalid_r;
    wire wr_ctrl = do_wr && wa == SLE_REG_CTRL && ws[0];
    wire wr_stat = do_wr && wa == SLE_REG_IRQ_STAT && ws[0];
    wire wr_mask = do_wr && wa == SLE_REG_IRQ_MASK && ws[0];
    wire wa_ok = wa == SLE_REG_CTRL || wa == SLE_REG_STAT || wa == SLE_REG_IRQ_STAT ||
        wa == SLE_REG_IRQ_MASK || wa == SLE_REG_LAMP_LO || wa == SLE_REG_LAMP_HI;

    // Lamp state packed for readback
    logic [32:0] lamp_flat;
    genvar gf;
    generate
        for (gf = 0; gf < SLE_NUM_LAMPS; gf++) begin : g_flat
            assign lamp_flat[gf*SLE_COLOR_W +: SLE_COLOR_W] = lamp_color[gf];
        end
    endgenerate

    wire [7:0] ra = s_axi_araddr;
    wire [31:0] rd_val =
        ra == SLE_REG_CTRL ? {30'h0, ctrl_r} :
        ra == SLE_REG_STAT ? {31'h0, blink_r} :
        ra == SLE_REG_IRQ_STAT ? {29'h0, irq_stat_r} :
        ra == SLE_REG_IRQ_MASK ? {29'h0, irq_mask_r} :
        ra == SLE_REG_LAMP_LO ? lamp_flat[31:0] :
        ra == SLE_REG_LAMP_HI ? {31'h0, lamp_flat[32]} : 32'h0;
    wire ra_ok = ra == SLE_REG_CTRL || ra == SLE_REG_STAT || ra == SLE_REG_IRQ_STAT ||
        ra == SLE_REG_IRQ_MASK || ra == SLE_REG_LAMP_LO || ra == SLE_REG_LAMP_HI;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            aw_addr_r <= '0;
            w_data_r <= '0;
            w_strb_r <= '0;
            bvalid_r <= 1'b0;
            bresp_r <= SLE_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            aw_hold_r <= aw_have && !do_wr;
            w_hold_r <= w_have && !do_wr;
            if (do_wr) begin
                bvalid_r <= 1'b1;
                bresp_r <= wa_ok ? SLE_RESP_OKAY : SLE_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= SLE_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_r <= 1'b1;
            rdata_r <= rd_val;
            rresp_r <= ra_ok ? SLE_RESP_OKAY : SLE_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    // Register state; hardware set wins over write-one-to-clear
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_r <= SLE_CTRL_RST;
            irq_mask_r <= '0;
            irq_stat_r <= '0;
            ev_prev_r <= '0;
        end else begin
            ev_prev_r <= ev_lvl;
            if (wr_ctrl) begin
                ctrl_r <= wd[1:0];
            end
            if (wr_mask) begin
                irq_mask_r <= wd[SLE_IRQ_W-1:0];
            end
            irq_stat_r <= (irq_stat_r & ~(wr_stat ? wd[SLE_IRQ_W-1:0] : '0)) | ev_rise;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_err_seen;
        en && !lamptest && s_pwr && s_err;
    endsequence
    property p_lamp1_err;
        @(posedge clk_sys) disable iff (!rst_n)
        s_err_seen |=> (lamp_color[0] == (blink_r ? SLE_RED : SLE_OFF)) || $changed(blink_r);
    endproperty
    a_lamp1_err: assert property (p_lamp1_err) else $error("lamp1 not red flash");
    property p_lamp1_ok;
        @(posedge clk_sys) disable iff (!rst_n)
        (en && !lamptest && s_pwr && !s_err && s_sso) |=> lamp_color[0] == SLE_GREEN;
    endproperty
    a_lamp1_ok: assert property (p_lamp1_ok) else $error("lamp1 not green");
    property p_lamp1_off;
        @(posedge clk_sys) disable iff (!rst_n)
        (!s_pwr) |=> lamp_color[0] == SLE_OFF;
    endproperty
    a_lamp1_off: assert property (p_lamp1_off) else $error("lamp1 lit unpowered");
    property p_lamp6;
        @(posedge clk_sys) disable iff (!rst_n)
        !lamptest |=> lamp_color[5] == SLE_OFF || $past(lamptest);
    endproperty
    a_lamp6: assert property (p_lamp6) else $error("lamp6 lit");
    property p_pwr_red;
        @(posedge clk_sys) disable iff (!rst_n)
        (en && !lamptest && s_pwr && s_stf) |=> lamp_color[6] == SLE_RED;
    endproperty
    a_pwr_red: assert property (p_pwr_red) else $error("power lamp not red");
    property p_lamp3;
        @(posedge clk_sys) disable iff (!rst_n)
        (en && !lamptest) |=> lamp_color[2] == ($past(s_wf) ? SLE_BLUE : SLE_OFF);
    endproperty
    a_lamp3: assert property (p_lamp3) else $error("lamp3 wrong");
    property p_blink_period;
        @(posedge clk_sys) disable iff (!rst_n)
        $changed(blink_r) |-> presc_r == '0;
    endproperty
    a_blink_period: assert property (p_blink_period) else $error("blink off phase");
    property p_lamp4_mode;
        @(posedge clk_sys) disable iff (!rst_n)
        (en && !lamptest && !s_four) |=> lamp_color[3] == SLE_OFF && lamp_color[4] == SLE_OFF;
    endproperty
    a_lamp4_mode: assert property (p_lamp4_mode) else $error("lamp4/5 outside mode");
    property p_net_bus;
        @(posedge clk_sys) disable iff (!rst_n)
        (en && !lamptest && s_n_bus_err) |=> lamp_color[8] == SLE_RED;
    endproperty
    a_net_bus: assert property (p_net_bus) else $error("network lamp not red");
endmodule : sle_status_lamp_encoder

// File: sle_status_lamp_encoder_tb_top.sv
`timescale 1ns/1ns
module sle_status_lamp_encoder_tb_top;
    import sle_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    // Always ready for answers, so no toggling between transfers
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    logic [1:0] s_axi_bresp, s_axi_rresp, port_link, port_activity;
    logic powered_on, safety_switch_output_on, device_error, restart_interlock_blocked;
    logic prot_field_occupied, linked_sensor_enabled, warn_field_int, four_field_mode;
    logic warn_field2_int, warn_field3_int, self_test_fail, internal_comm_fault, wave_active;
    logic safety_proto_init, safety_proto_active, safety_proto_passive, safety_proto_cfg_fail;
    logic safety_proto_comm_err, net_init, net_bus_init, net_data_exchange, net_topology_err;
    logic net_cfg_fail, net_bus_err, ph;
    sle_color_t lamp_color [SLE_NUM_LAMPS];
    sle_color_t seen [SLE_NUM_LAMPS];
    int mismatches = 0;
    int cmp_count = 0;
    logic [31:0] d;
    logic [1:0] r;

    always #5 clk_sys = ~clk_sys;

    sle_status_lamp_encoder i_sle_status_lamp_encoder (
        .clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .powered_on, .safety_switch_output_on, .device_error,
        .restart_interlock_blocked, .prot_field_occupied, .linked_sensor_enabled,
        .warn_field_int, .four_field_mode, .warn_field2_int, .warn_field3_int, .self_test_fail,
        .internal_comm_fault, .wave_active, .safety_proto_init, .safety_proto_active,
        .safety_proto_passive, .safety_proto_cfg_fail, .safety_proto_comm_err, .net_init,
        .net_bus_init, .net_data_exchange, .net_topology_err, .net_cfg_fail, .net_bus_err,
        .port_link, .port_activity, .lamp_color, .irq
    );

    sle_lamp_viewer i_sle_lamp_viewer (.clk_sys, .lamp_color, .seen);

    // ****************************************
    // Helpers
    // ****************************************
    task automatic end_of_test();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test

    task automatic tmo();
        mismatches++;
        end_of_test();
    endtask : tmo

    task automatic ck(input int k, input sle_color_t e);
        cmp_count++;
        if (seen[k] !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t lamp %0d got %h exp %h", $time, k, seen[k], e);
        end
    endtask : ck

    task automatic ckw(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask : ckw

    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        rs = s_axi_bresp;
        if (n == 20) tmo();
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk_sys);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        v = s_axi_rdata;
        rs = s_axi_rresp;
        if (n == 20) tmo();
    endtask : rd

    task automatic clr(input logic pon);
        {powered_on, safety_switch_output_on, device_error, restart_interlock_blocked,
         prot_field_occupied, linked_sensor_enabled, warn_field_int, four_field_mode,
         warn_field2_int, warn_field3_int, self_test_fail, internal_comm_fault, wave_active,
         safety_proto_init, safety_proto_active, safety_proto_passive, safety_proto_cfg_fail,
         safety_proto_comm_err, net_init, net_bus_init, net_data_exchange, net_topology_err,
         net_cfg_fail, net_bus_err, port_link, port_activity} <= {pon, 27'h0};
    endtask : clr

    // Blink half period far exceeds the run, so flash state is read back
    task automatic settle();
        repeat (5) @(posedge clk_sys);
        rd(SLE_REG_STAT, d, r);
        ph = d[0];
    endtask : settle

    function automatic sle_color_t fl(input sle_color_t c);
        return ph ? c : SLE_OFF;
    endfunction : fl

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        rd(SLE_REG_CTRL, d, r);
        ckw(d, 32'h1);
        rd(SLE_REG_IRQ_MASK, d, r);
        ckw(d, 32'h0);
        // Byte lane 0 off: the control write must not land
        s_axi_wstrb <= 4'he;
        wr(SLE_REG_CTRL, 32'h0, r);
        s_axi_wstrb <= 4'hf;
        rd(SLE_REG_CTRL, d, r);
        ckw(d, 32'h1);
        rd(8'h40, d, r);
        ckw({d[31:2], r}, {30'h0, SLE_RESP_SLVERR});
        wr(8'h44, 32'hffff_ffff, r);
        ckw({30'h0, r}, {30'h0, SLE_RESP_SLVERR});
    endtask : t_regs

    task automatic t_main_power();
        clr(1'b0);
        settle();
        ck(0, SLE_OFF);
        ck(6, SLE_OFF);
        powered_on <= 1'b1;
        safety_switch_output_on <= 1'b1;
        settle();
        ck(0, SLE_GREEN);
        ck(6, SLE_GREEN);
        safety_switch_output_on <= 1'b0;
        settle();
        ck(0, SLE_RED);
        safety_switch_output_on <= 1'b1;
        device_error <= 1'b1;
        self_test_fail <= 1'b1;
        wave_active <= 1'b1;
        settle();
        ck(0, fl(SLE_RED));
        ck(6, SLE_RED);
        ck(7, fl(SLE_GREEN));
        ck(8, fl(SLE_GREEN));
        self_test_fail <= 1'b0;
        internal_comm_fault <= 1'b1;
        settle();
        ck(6, SLE_RED);
        internal_comm_fault <= 1'b0;
        settle();
        ck(6, fl(SLE_GREEN));
    endtask : t_main_power

    task automatic t_fields();
        clr(1'b1);
        settle();
        ck(1, SLE_OFF);
        ck(2, SLE_OFF);
        ck(3, SLE_OFF);
        restart_interlock_blocked <= 1'b1;
        prot_field_occupied <= 1'b1;
        settle();
        ck(1, fl(SLE_YELLOW));
        prot_field_occupied <= 1'b0;
        linked_sensor_enabled <= 1'b1;
        warn_field_int <= 1'b1;
        four_field_mode <= 1'b1;
        warn_field2_int <= 1'b1;
        warn_field3_int <= 1'b1;
        settle();
        ck(1, SLE_YELLOW);
        ck(2, SLE_BLUE);
        ck(3, SLE_BLUE);
        ck(4, fl(SLE_YELLOW));
        ck(5, SLE_OFF);
    endtask : t_fields

    task automatic t_safety_net();
        clr(1'b1);
        @(posedge clk_sys);
        safety_proto_init <= 1'b1;
        safety_proto_active <= 1'b1;
        net_init <= 1'b1;
        net_data_exchange <= 1'b1;
        settle();
        ck(7, SLE_GREEN);
        ck(8, SLE_GREEN);
        safety_proto_passive <= 1'b1;
        net_bus_init <= 1'b1;
        settle();
        ck(7, fl(SLE_GREEN));
        ck(8, fl(SLE_GREEN));
        safety_proto_cfg_fail <= 1'b1;
        net_topology_err <= 1'b1;
        settle();
        ck(7, fl(SLE_RED));
        ck(8, fl(SLE_ORANGE));
        safety_proto_comm_err <= 1'b1;
        net_cfg_fail <= 1'b1;
        settle();
        ck(7, SLE_RED);
        ck(8, fl(SLE_RED));
        net_bus_err <= 1'b1;
        settle();
        ck(8, SLE_RED);
    endtask : t_safety_net

    task automatic t_ports();
        clr(1'b1);
        @(posedge clk_sys);
        port_link <= 2'b01;
        port_activity <= 2'b10;
        settle();
        ck(9, SLE_GREEN);
        ck(10, SLE_OFF);
        port_link <= 2'b11;
        port_activity <= 2'b01;
        settle();
        ck(9, ph ? SLE_ORANGE : SLE_GREEN);
        ck(10, SLE_GREEN);
        rd(SLE_REG_LAMP_LO, d, r);
        ckw(d, 32'h4004_0002 | (32'(ph ? SLE_ORANGE : SLE_GREEN) << 27));
        rd(SLE_REG_LAMP_HI, d, r);
        ckw(d, 32'h0);
    endtask : t_ports

    task automatic t_ctrl_irq();
        wr(SLE_REG_CTRL, 32'h3, r);
        settle();
        for (int k = 0; k < SLE_NUM_LAMPS; k++) ck(k, SLE_GREEN);
        wr(SLE_REG_CTRL, 32'h0, r);
        settle();
        for (int k = 0; k < SLE_NUM_LAMPS; k++) ck(k, SLE_OFF);
        wr(SLE_REG_CTRL, 32'h1, r);
        clr(1'b1);
        wr(SLE_REG_IRQ_STAT, 32'h7, r);
        device_error <= 1'b1;
        self_test_fail <= 1'b1;
        settle();
        rd(SLE_REG_IRQ_STAT, d, r);
        ckw(d, 32'h3);
        ckw({31'h0, irq}, 32'h0);
        wr(SLE_REG_IRQ_MASK, 32'h4, r);
        ckw({31'h0, irq}, 32'h0);
        wr(SLE_REG_IRQ_MASK, 32'h2, r);
        ckw({31'h0, irq}, 32'h1);
        wr(SLE_REG_IRQ_STAT, 32'h2, r);
        ckw({31'h0, irq}, 32'h0);
        rd(SLE_REG_IRQ_STAT, d, r);
        ckw(d, 32'h1);
    endtask : t_ctrl_irq

    initial begin
        clr(1'b0);
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_main_power();
        t_fields();
        t_safety_net();
        t_ports();
        t_ctrl_irq();
        end_of_test();
    end
endmodule : sle_status_lamp_encoder_tb_top
